// ---- rtl/isp_map.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * instrument serial port.
 * Assumes a 40 MHz pclk and word-aligned APB byte addresses.
 */
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

// register byte offsets
`define ISP_CFG_OFF      8'h00
`define ISP_STATUS_OFF   8'h04
`define ISP_TXDATA_OFF   8'h08
`define ISP_RXDATA_OFF   8'h0c

// configuration fields
`define ISP_CFG_BAUD_LSB   0
`define ISP_CFG_BAUD_MSB   2
`define ISP_CFG_PAR_LSB    3
`define ISP_CFG_PAR_MSB    5
`define ISP_CFG_LEN8       6
`define ISP_CFG_STOP2      7
`define ISP_CFG_RXPACE     8
`define ISP_CFG_TXPACE     9
`define ISP_CFG_ROUTE_PROG 10
`define ISP_CFG_OUT_ECHO   11
`define ISP_CFG_RX_ECHO    12
`define ISP_CFG_W          13
// 9600 baud, no parity, 8 bits, 1 stop, both pacings on, command line,
// both echoes on
`define ISP_CFG_RESET      13'h1b46

// status fields and the receive data valid bit
`define ISP_ST_COUNT_LSB   0
`define ISP_ST_COUNT_MSB   10
`define ISP_ST_TXHALT      16
`define ISP_ST_PARERR      17
`define ISP_ST_FRMERR      18
`define ISP_ST_OVERRUN     19
`define ISP_ST_XOFFSENT    20
`define ISP_RX_VALID       8

// timing and flow control
`define ISP_CLK_HZ         40000000
`define ISP_XON            8'h11
`define ISP_XOFF           8'h13
`define ISP_RXBUF_DEPTH    2000
`define ISP_TXBUF_DEPTH    4
`define ISP_RX_HI          11'd1984
`define ISP_RX_LO          11'd1024

`endif

// ---- rtl/isp_pkg.sv ----
/*
 * Types of the instrument serial port.
 * Assumes isp_map.svh supplies the numbers.
 */
package isp_pkg;

    typedef enum logic [2:0]
    {
        ISP_PAR_NONE = 3'h0,
        ISP_PAR_ODD = 3'h1,
        ISP_PAR_EVEN = 3'h2,
        ISP_PAR_ONE = 3'h3,
        ISP_PAR_ZERO = 3'h4
    } isp_parity_e;

    typedef enum logic [4:0]
    {
        ISP_IDLE = 5'h01,
        ISP_START = 5'h02,
        ISP_DATA = 5'h04,
        ISP_PAR = 5'h08,
        ISP_STOP = 5'h10
    } isp_state_e;

    typedef logic [18:0] isp_div_t;

endpackage

// ---- rtl/isp_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; clr empties it without touching its contents.
 */
`timescale 1ns/10ps
`default_nettype none

module isp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] next_count;
    logic push, pop;

    // full and empty come straight from the count
    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers wrap at DEPTH, which need not be a power of two
    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (clr)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
        else
        begin
            if (push)
                next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (push & ~pop)
                next_count = count + 1'b1;
            else if (pop & ~push)
                next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset
    always_ff @(posedge clk)
    begin
        if (push && !clr)
            mem[wr_ptr] <= in_data;
    end

endmodule

`default_nettype wire

// ---- rtl/isp_top.sv ----
/*
 * Asynchronous serial port of the instrument: APB registers, transmitter,
 * receiver, xon/xoff pacing, echo paths and receive buffer.
 * Assumes rxd is already synchronous to pclk; presetn is power-on reset.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "isp_map.svh"

module isp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_preset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic cmd_valid,
    output logic [7:0] cmd_char,
    input wire logic interp_valid,
    input wire logic [7:0] interp_char,
    output logic interp_ready
);
    import isp_pkg::*;

    logic [`ISP_CFG_W-1:0] cfg, next_cfg;
    isp_parity_e par_mode;
    isp_div_t bit_div;
    logic len8, stop2, rx_pace, tx_pace, route_prog, out_echo, rx_echo;

    // configuration fields
    assign par_mode = isp_parity_e'(cfg[`ISP_CFG_PAR_MSB:`ISP_CFG_PAR_LSB]);
    assign len8 = cfg[`ISP_CFG_LEN8];
    assign stop2 = cfg[`ISP_CFG_STOP2];
    assign rx_pace = cfg[`ISP_CFG_RXPACE];
    assign tx_pace = cfg[`ISP_CFG_TXPACE];
    assign route_prog = cfg[`ISP_CFG_ROUTE_PROG];
    assign out_echo = cfg[`ISP_CFG_OUT_ECHO];
    assign rx_echo = cfg[`ISP_CFG_RX_ECHO];

    // cycles per bit for each rate code
    always_comb
    begin
        unique case (cfg[`ISP_CFG_BAUD_MSB:`ISP_CFG_BAUD_LSB])
            3'h0: bit_div = isp_div_t'(`ISP_CLK_HZ / 150);
            3'h1: bit_div = isp_div_t'(`ISP_CLK_HZ / 300);
            3'h2: bit_div = isp_div_t'(`ISP_CLK_HZ / 600);
            3'h3: bit_div = isp_div_t'(`ISP_CLK_HZ / 1200);
            3'h4: bit_div = isp_div_t'(`ISP_CLK_HZ / 2400);
            3'h5: bit_div = isp_div_t'(`ISP_CLK_HZ / 4800);
            3'h6: bit_div = isp_div_t'(`ISP_CLK_HZ / 9600);
            3'h7: bit_div = isp_div_t'(`ISP_CLK_HZ / 19200);
        endcase
    end

    // parity of a character under the current mode
    function automatic logic par_of(input logic [7:0] d, isp_parity_e m);
        unique case (m)
            ISP_PAR_ODD: par_of = ~(^d);
            ISP_PAR_EVEN: par_of = ^d;
            ISP_PAR_ONE: par_of = 1'b1;
            default: par_of = 1'b0;
        endcase
    endfunction

    // ---------------- buffers ----------------
    logic tq_in_valid, tq_in_ready, tq_out_valid, tq_out_ready;
    logic [7:0] tq_in_data, tq_out_data;
    logic [2:0] tq_count;
    logic rq_in_valid, rq_in_ready, rq_out_valid, rq_out_ready;
    logic [7:0] rq_out_data;
    logic [10:0] rq_count;
    logic [7:0] rx_char;

    isp_fifo #(.WIDTH(8), .DEPTH(`ISP_TXBUF_DEPTH)) u_txq (
        .clk(pclk),
        .rst_n(presetn),
        .clr(soft_preset),
        .in_valid(tq_in_valid),
        .in_ready(tq_in_ready),
        .in_data(tq_in_data),
        .out_valid(tq_out_valid),
        .out_ready(tq_out_ready),
        .out_data(tq_out_data),
        .count(tq_count)
    );

    isp_fifo #(.WIDTH(8), .DEPTH(`ISP_RXBUF_DEPTH)) u_rxq (
        .clk(pclk),
        .rst_n(presetn),
        .clr(soft_preset),
        .in_valid(rq_in_valid),
        .in_ready(rq_in_ready),
        .in_data(rx_char),
        .out_valid(rq_out_valid),
        .out_ready(rq_out_ready),
        .out_data(rq_out_data),
        .count(rq_count)
    );

    // ---------------- apb slave ----------------
    logic acc, apb_tx_wr, apb_cfg_wr, apb_st_wr, apb_rx_rd, map_hit;
    logic [31:0] next_prdata, status;
    logic par_err, frm_err, ovr_err, tx_halt, xoff_sent;

    assign map_hit = (paddr == `ISP_CFG_OFF) || (paddr == `ISP_STATUS_OFF)
        || (paddr == `ISP_TXDATA_OFF) || (paddr == `ISP_RXDATA_OFF);
    // only a full transmit queue stretches an access
    assign pready = ~(pwrite && paddr == `ISP_TXDATA_OFF && !tq_in_ready);
    assign pslverr = psel & penable & ~map_hit;
    assign acc = psel & penable & pready & map_hit;
    assign apb_cfg_wr = acc & pwrite & (paddr == `ISP_CFG_OFF);
    assign apb_st_wr = acc & pwrite & (paddr == `ISP_STATUS_OFF);
    assign apb_tx_wr = acc & pwrite & (paddr == `ISP_TXDATA_OFF);
    assign apb_rx_rd = acc & ~pwrite & (paddr == `ISP_RXDATA_OFF);
    assign rq_out_ready = apb_rx_rd;

    always_comb
    begin
        status = '0;
        status[`ISP_ST_COUNT_MSB:`ISP_ST_COUNT_LSB] = rq_count;
        status[`ISP_ST_TXHALT] = tx_halt;
        status[`ISP_ST_PARERR] = par_err;
        status[`ISP_ST_FRMERR] = frm_err;
        status[`ISP_ST_OVERRUN] = ovr_err;
        status[`ISP_ST_XOFFSENT] = xoff_sent;
    end

    // read data captured in the setup cycle; the head cannot move before
    // the access completes because only this bus pops it
    always_comb
    begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite)
        begin
            next_prdata = '0;
            if (paddr == `ISP_CFG_OFF)
                next_prdata[`ISP_CFG_W-1:0] = cfg;
            else if (paddr == `ISP_STATUS_OFF)
                next_prdata = status;
            else if (paddr == `ISP_RXDATA_OFF)
                next_prdata[8:0] = {rq_out_valid, rq_out_data};
        end
        // settings only change by software; soft_preset leaves them alone
        next_cfg = apb_cfg_wr ? pwdata[`ISP_CFG_W-1:0] : cfg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            cfg <= `ISP_CFG_RESET;
        end
        else
        begin
            prdata <= next_prdata;
            cfg <= next_cfg;
        end
    end

    // transmit queue: bus writes first, then interpreter output
    assign tq_in_valid = apb_tx_wr | (interp_valid & out_echo);
    assign tq_in_data = apb_tx_wr ? pwdata[7:0] : interp_char;
    // output is swallowed when echo is off so the interpreter never stalls
    assign interp_ready = ~out_echo | (tq_in_ready & ~apb_tx_wr);

    // ---------------- receiver ----------------
    isp_state_e rx_st, next_rx_st;
    isp_div_t rx_cnt, next_rx_cnt;
    logic [2:0] rx_bit, next_rx_bit;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_pbad, next_rx_pbad, rx_done, rx_fbad;
    logic next_cmd_valid;
    logic [7:0] next_cmd_char;

    assign rx_char = len8 ? rx_sh : {1'b0, rx_sh[7:1]};

    // counter reloads at half a bit for the start, so each sample is mid-bit
    always_comb
    begin
        next_rx_st = rx_st;
        next_rx_cnt = (rx_cnt == '0) ? '0 : rx_cnt - 1'b1;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_pbad = rx_pbad;
        rx_done = 1'b0;
        rx_fbad = 1'b0;
        unique case (rx_st)
            ISP_IDLE:
                if (!rxd)
                begin
                    next_rx_st = ISP_START;
                    next_rx_cnt = bit_div >> 1;
                end
            ISP_START:
                if (rx_cnt == '0)
                begin
                    // a glitch shorter than half a bit is dropped
                    next_rx_st = rxd ? ISP_IDLE : ISP_DATA;
                    next_rx_cnt = bit_div;
                    next_rx_bit = len8 ? 3'h7 : 3'h6;
                    next_rx_pbad = 1'b0;
                end
            ISP_DATA:
                if (rx_cnt == '0)
                begin
                    next_rx_sh = {rxd, rx_sh[7:1]};
                    next_rx_cnt = bit_div;
                    next_rx_bit = rx_bit - 1'b1;
                    if (rx_bit == '0)
                        next_rx_st = (par_mode == ISP_PAR_NONE) ? ISP_STOP
                            : ISP_PAR;
                end
            ISP_PAR:
                if (rx_cnt == '0)
                begin
                    next_rx_pbad = (rxd != par_of(rx_char, par_mode));
                    next_rx_cnt = bit_div;
                    next_rx_st = ISP_STOP;
                end
            ISP_STOP:
                if (rx_cnt == '0)
                begin
                    // only the first stop bit is checked; a second one
                    // merely looks like idle line
                    rx_done = 1'b1;
                    rx_fbad = ~rxd;
                    next_rx_st = ISP_IDLE;
                end
        endcase
        if (soft_preset)
            next_rx_st = ISP_IDLE;
    end

    logic rx_is_flow;
    // pacing characters are consumed, not delivered, when tx pacing is on
    assign rx_is_flow = tx_pace && (rx_char == `ISP_XON
        || rx_char == `ISP_XOFF);
    assign rq_in_valid = rx_done & ~rx_is_flow & route_prog;

    // command line gets each character as a one-cycle strobe
    always_comb
    begin
        next_cmd_valid = rx_done & ~rx_is_flow & ~route_prog;
        next_cmd_char = next_cmd_valid ? rx_char : cmd_char;
    end

    // ---------------- transmitter ----------------
    isp_state_e tx_st, next_tx_st;
    isp_div_t tx_cnt, next_tx_cnt;
    logic [2:0] tx_bit, next_tx_bit;
    logic [7:0] tx_sh, next_tx_sh;
    logic tx_stops, next_tx_stops, next_txd, tx_par, next_tx_par;
    logic echo_pend, next_echo_pend, echo_take;
    logic [7:0] echo_char, next_echo_char;
    logic next_tx_halt, next_xoff_sent;
    logic next_par_err, next_frm_err, next_ovr_err;
    logic want_xoff, want_xon;

    // xoff near full, xon once the program has drained half
    assign want_xoff = rx_pace && !xoff_sent && rq_count >= `ISP_RX_HI;
    assign want_xon = xoff_sent && (!rx_pace || rq_count <= `ISP_RX_LO);

    always_comb
    begin
        next_tx_st = tx_st;
        next_tx_cnt = (tx_cnt == '0) ? '0 : tx_cnt - 1'b1;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        next_tx_par = tx_par;
        next_tx_stops = tx_stops;
        next_txd = txd;
        next_xoff_sent = xoff_sent;
        tq_out_ready = 1'b0;
        echo_take = 1'b0;
        unique case (tx_st)
            ISP_IDLE:
            begin
                next_txd = 1'b1;
                // flow characters first, then echo, then queued output
                if (want_xoff || want_xon || echo_pend
                    || (tq_out_valid && !(tx_pace && tx_halt)))
                begin
                    if (want_xoff || want_xon)
                    begin
                        next_tx_sh = want_xoff ? `ISP_XOFF : `ISP_XON;
                        next_xoff_sent = want_xoff;
                    end
                    else if (echo_pend)
                    begin
                        next_tx_sh = echo_char;
                        echo_take = 1'b1;
                    end
                    else
                    begin
                        next_tx_sh = tq_out_data;
                        tq_out_ready = 1'b1;
                    end
                    // bit 7 is never sent in 7-bit mode, so keep it out
                    next_tx_par = par_of(len8 ? next_tx_sh
                        : {1'b0, next_tx_sh[6:0]}, par_mode);
                    next_tx_st = ISP_START;
                    next_tx_cnt = bit_div;
                    next_txd = 1'b0;
                end
            end
            ISP_START:
                if (tx_cnt == '0)
                begin
                    next_tx_st = ISP_DATA;
                    next_tx_cnt = bit_div;
                    next_tx_bit = len8 ? 3'h7 : 3'h6;
                    next_txd = tx_sh[0];
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                end
            ISP_DATA:
                if (tx_cnt == '0)
                begin
                    next_tx_cnt = bit_div;
                    next_tx_bit = tx_bit - 1'b1;
                    next_txd = tx_sh[0];
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                    if (tx_bit == '0)
                    begin
                        next_tx_st = (par_mode == ISP_PAR_NONE) ? ISP_STOP
                            : ISP_PAR;
                        next_txd = (par_mode == ISP_PAR_NONE) ? 1'b1
                            : tx_par;
                        next_tx_stops = stop2;
                    end
                end
            ISP_PAR:
                if (tx_cnt == '0)
                begin
                    next_tx_st = ISP_STOP;
                    next_tx_cnt = bit_div;
                    next_txd = 1'b1;
                end
            ISP_STOP:
                if (tx_cnt == '0)
                begin
                    next_tx_cnt = bit_div;
                    next_tx_stops = 1'b0;
                    if (!tx_stops)
                        next_tx_st = ISP_IDLE;
                end
        endcase
        if (soft_preset)
        begin
            next_tx_st = ISP_IDLE;
            next_txd = 1'b1;
            next_xoff_sent = 1'b0;
        end
    end

    // echo slot, flags and pacing state; a set beats a same-cycle status write clear; soft_preset beats an echo or halt set but leaves the flags alone
    always_comb
    begin
        next_echo_pend = (echo_pend & ~echo_take)
            | (rx_done & rx_echo);
        next_echo_char = (rx_done & rx_echo) ? rx_char : echo_char;
        next_tx_halt = tx_halt;
        if (!tx_pace)
            next_tx_halt = 1'b0;
        else if (rx_done && rx_char == `ISP_XOFF)
            next_tx_halt = 1'b1;
        else if (rx_done && rx_char == `ISP_XON)
            next_tx_halt = 1'b0;
        next_par_err = (par_err & ~(apb_st_wr & pwdata[`ISP_ST_PARERR]))
            | (rx_done & rx_pbad);
        next_frm_err = (frm_err & ~(apb_st_wr & pwdata[`ISP_ST_FRMERR]))
            | rx_fbad;
        next_ovr_err = (ovr_err & ~(apb_st_wr & pwdata[`ISP_ST_OVERRUN]))
            | (rq_in_valid & ~rq_in_ready);
        if (soft_preset)
        begin
            next_echo_pend = 1'b0;
            next_tx_halt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st <= ISP_IDLE;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_sh <= '0;
            rx_pbad <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_char <= '0;
            tx_st <= ISP_IDLE;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_sh <= '0;
            tx_par <= 1'b0;
            tx_stops <= 1'b0;
            txd <= 1'b1;
            echo_pend <= 1'b0;
            echo_char <= '0;
            tx_halt <= 1'b0;
            xoff_sent <= 1'b0;
            par_err <= 1'b0;
            frm_err <= 1'b0;
            ovr_err <= 1'b0;
        end
        else
        begin
            rx_st <= next_rx_st;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_pbad <= next_rx_pbad;
            cmd_valid <= next_cmd_valid;
            cmd_char <= next_cmd_char;
            tx_st <= next_tx_st;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            tx_par <= next_tx_par;
            tx_stops <= next_tx_stops;
            txd <= next_txd;
            echo_pend <= next_echo_pend;
            echo_char <= next_echo_char;
            tx_halt <= next_tx_halt;
            xoff_sent <= next_xoff_sent;
            par_err <= next_par_err;
            frm_err <= next_frm_err;
            ovr_err <= next_ovr_err;
        end
    end

endmodule

`default_nettype wire

// ---- bench/isp_top_properties.sv ----
/* Assertions on the serial port's pins, bound to every isp_top.
   Assumes one pclk domain with presetn as its only reset. */
`timescale 1ns/10ps
`default_nettype none

module isp_top_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_preset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_char,
    input wire logic interp_valid,
    input wire logic [7:0] interp_char,
    input wire logic interp_ready
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // read setup loads prdata; nothing else may move it
    logic rd_s;
    assign rd_s = psel && !penable && !pwrite;

    // access phase of a transfer
    sequence acc;
        psel && penable;
    endsequence
    // a start bit must outlast any glitch
    sequence low8;
        !txd [*8];
    endsequence

    AST_TXD_RESET: assert property ($rose(presetn) |-> txd)
        else $error("txd not idle after reset");
    AST_START_BIT: assert property ($fell(txd) |-> low8)
        else $error("start bit too short");
    AST_UNMAPPED: assert property (acc ##0 paddr > 8'h0c |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (acc ##0 paddr[1:0] == 2'h0
        && paddr <= 8'h0c |-> !pslverr)
        else $error("mapped access refused");
    AST_NO_WAIT: assert property (acc ##0 !(pwrite
        && paddr == 8'h08) |-> pready)
        else $error("wait state outside full tx write");
    AST_PRDATA_HOLD: assert property (!rd_s |=> $stable(prdata))
        else $error("prdata moved without read");
    AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("cmd_valid longer than one cycle");
    AST_CMD_HOLD: assert property (!cmd_valid |-> $stable(cmd_char))
        else $error("cmd_char moved without cmd_valid");
endmodule

bind isp_top isp_top_properties CHK (.*);

`default_nettype wire

// ---- bench/isp_far_end.sv ----
/* Far-end terminal model: sends 8N1 frames on rxd, decodes txd.
   Assumes the port runs 19200 baud, 8 bits, no parity, 1 stop. */
`timescale 1ns/10ps
`default_nettype none

module isp_far_end #(
    parameter int BIT = 2084
) (
    input wire logic clk,
    input wire logic txd, // only tx, rx and ground
    output logic rxd
);
    logic [7:0] got [$];

    // idle high; no local echo, and xoff only when the bench sends one
    initial rxd = 1'b1;

    // start, data lsb first, one stop, BIT cycles each
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask

    // mid-bit decode; a low stop bit is logged as 8'hee
    initial
    begin
        logic [7:0] c;
        forever
        begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge clk);
                c[i] = txd;
            end
            repeat (BIT) @(posedge clk);
            got.push_back(txd ? c : 8'hee);
        end
    end
endmodule

`default_nettype wire

// ---- bench/isp_top_bench.sv ----
/* Bench for isp_top: APB tasks, far-end model, echo and buffer paths.
   Assumes a 40 MHz pclk and the port run at 19200 baud. */
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
        num_errors++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end

module isp_top_bench;
    logic pclk, presetn, soft_preset, psel, penable, pwrite, pready, pslverr;
    logic rxd, txd, cmd_valid, interp_valid, interp_ready;
    logic [7:0] paddr, cmd_char, interp_char, last_cmd;
    logic [31:0] pwdata, prdata, rd;
    int num_errors = 0;
    int tests_run = 0;
    int ncmd = 0;

    isp_top DUT (.*);
    isp_far_end FE (.clk(pclk), .txd(txd), .rxd(rxd));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // log command-line deliveries
    always @(posedge pclk)
        if (cmd_valid === 1'b1)
        begin
            ncmd++;
            last_cmd = cmd_char;
        end

    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // bounded wait for n decoded characters
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (FE.got.size() < n && k < 80000)
        begin
            @(posedge pclk);
            k++;
        end
        if (k == 80000)
        begin
            num_errors++;
            summarize();
        end
    endtask

    initial
    begin
        {presetn, soft_preset, psel, penable, pwrite} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        interp_valid = 1'b0;
        interp_char = 8'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0, rd);
        `CHK("cfg reset", 32'h1b46, rd)
        apb(1'b0, 8'h10, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        apb(1'b1, 8'h00, 32'h1b47, rd);
        apb(1'b0, 8'h00, 32'h0, rd);
        `CHK("cfg baud", 32'h1b47, rd)
        // a panel preset empties buffers but keeps the settings
        soft_preset <= 1'b1;
        @(posedge pclk);
        soft_preset <= 1'b0;
        apb(1'b0, 8'h00, 32'h0, rd);
        `CHK("cfg kept", 32'h1b47, rd)
        // output goes out first; the echo waits for the line
        interp_char <= 8'h5a;
        interp_valid <= 1'b1;
        @(posedge pclk);
        `CHK("interp ready", 1'b1, interp_ready)
        interp_valid <= 1'b0;
        FE.send(8'h41);
        wait_got(2);
        `CHK("out echo", 8'h5a, FE.got[0])
        `CHK("rx echo", 8'h41, FE.got[1])
        `CHK("cmd char", 8'h41, last_cmd)
        `CHK("cmd count", 1, ncmd)
        // program route, rx echo off, tx and rx at once
        apb(1'b1, 8'h00, 32'h0f47, rd);
        apb(1'b1, 8'h08, 32'h33, rd);
        FE.send(8'h42);
        apb(1'b0, 8'h04, 32'h0, rd);
        `CHK("status", 32'h1, rd)
        apb(1'b0, 8'h0c, 32'h0, rd);
        `CHK("rx pop", 32'h142, rd)
        apb(1'b0, 8'h0c, 32'h0, rd);
        `CHK("rx empty", 1'b0, rd[8])
        wait_got(3);
        `CHK("tx data", 8'h33, FE.got[2])
        `CHK("cmd count", 1, ncmd)
        // xoff from the far end is consumed and holds the queue back
        FE.send(8'h13);
        apb(1'b1, 8'h08, 32'h55, rd);
        apb(1'b0, 8'h04, 32'h0, rd);
        `CHK("halted", 32'h10000, rd)
        repeat (200) @(posedge pclk);
        `CHK("no echo", 1'b1, txd)
        `CHK("held", 3, FE.got.size())
        summarize();
    end
endmodule

`default_nettype wire
